// ### lfb_addr_form.sv
// Data address former for byte and bit register operands.
`timescale 1ns/1ns
module lfb_addr_form (
    input wire logic i_bank_bit,
    input wire logic [7:0] i_file_addr,
    input wire logic [3:0] i_bank_select_pointer,
    input wire logic i_ext_set_en,
    input wire logic [lfb_pkg::DADDR_W-1:0] i_index_base,
    output logic [lfb_pkg::DADDR_W-1:0] o_data_addr
);

    logic low_part;

    // Operands at or below the split sit in the lower half of the access bank.
    assign low_part = (i_file_addr <= lfb_pkg::ACCESS_SPLIT);

    // Bank bit set uses the bank pointer; clear uses the access bank, unless the
    // extended set turns a low operand into an offset from the index base.
    always_comb
    begin
        if (i_bank_bit)
        begin
            o_data_addr = {i_bank_select_pointer, i_file_addr};
        end
        else if (i_ext_set_en && low_part)
        begin
            o_data_addr = i_index_base + {4'h0, i_file_addr};
        end
        else if (low_part)
        begin
            o_data_addr = {lfb_pkg::ACCESS_LOW_BANK, i_file_addr};
        end
        else
        begin
            o_data_addr = {lfb_pkg::ACCESS_HIGH_BANK, i_file_addr};
        end
    end

endmodule

// ### lfb_exec.sv
// Decode and execute of AND, bit clear and flag branches over four phases.
`timescale 1ns/1ns
module lfb_exec (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [lfb_pkg::INSTR_W-1:0] i_instr,
    input wire logic [7:0] i_mem_rdata,
    input wire logic [3:0] i_bank_select_pointer,
    input wire logic i_ext_set_en,
    input wire logic [lfb_pkg::DADDR_W-1:0] i_index_base,
    input wire logic i_carry_flag,
    input wire logic i_overflow_flag,
    output logic [3:0] o_phase,
    output logic [lfb_pkg::PC_W-1:0] o_pc,
    output logic [7:0] o_wreg,
    output logic o_neg_flag,
    output logic o_zero_flag,
    output logic [lfb_pkg::DADDR_W-1:0] o_mem_addr,
    output logic o_mem_rd,
    output logic o_mem_we,
    output logic [7:0] o_mem_wdata,
    output logic o_discard
);

    lfb_pkg::lfb_phase_e phase_q, phase_d;
    logic [lfb_pkg::INSTR_W-1:0] ir_q, ir_d;
    logic [lfb_pkg::PC_W-1:0] pc_q, pc_d;
    logic [7:0] wreg_q, wreg_d;
    logic [7:0] res_q, res_d;
    logic neg_q, neg_d;
    logic zero_q, zero_d;
    logic flush_q, flush_d;
    logic [lfb_pkg::DADDR_W-1:0] addr_q, addr_d;
    logic rd_q, rd_d;
    logic we_q, we_d;
    logic [7:0] wdata_q, wdata_d;
    logic [lfb_pkg::DADDR_W-1:0] operand_addr;
    lfb_pkg::lfb_op_e op;
    logic taken;

    // Top of the three-bit bit index field.
    localparam int BITIDX_HI = lfb_pkg::BITIDX_LSB + 2;

    // Sort an instruction word into the operations this slice executes.
    function automatic lfb_pkg::lfb_op_e op_decode(input logic [lfb_pkg::INSTR_W-1:0] w);
        lfb_pkg::lfb_op_e k;
        k = lfb_pkg::OP_NONE;
        if (w[15:8] == lfb_pkg::OPC_AND_IMM)
        begin
            k = lfb_pkg::OP_AND_IMM;
        end
        else if (w[15:10] == lfb_pkg::OPC_AND_FILE)
        begin
            k = lfb_pkg::OP_AND_FILE;
        end
        else if (w[15:12] == lfb_pkg::OPC_BIT_CLR)
        begin
            k = lfb_pkg::OP_BIT_CLR;
        end
        else if (w[15:8] == lfb_pkg::OPC_BR_CARRY)
        begin
            k = lfb_pkg::OP_BR_CARRY;
        end
        else if (w[15:8] == lfb_pkg::OPC_BR_NO_CARRY)
        begin
            k = lfb_pkg::OP_BR_NO_CARRY;
        end
        else if (w[15:8] == lfb_pkg::OPC_BR_NEG)
        begin
            k = lfb_pkg::OP_BR_NEG;
        end
        else if (w[15:8] == lfb_pkg::OPC_BR_NOT_NEG)
        begin
            k = lfb_pkg::OP_BR_NOT_NEG;
        end
        else if (w[15:8] == lfb_pkg::OPC_BR_NO_OVF)
        begin
            k = lfb_pkg::OP_BR_NO_OVF;
        end
        return k;
    endfunction

    // Whether a branch operation finds its condition met.
    function automatic logic cond_met(input lfb_pkg::lfb_op_e k, input logic c,
                                      input logic n, input logic ov);
        logic m;
        m = 1'b0;
        unique case (k)
            lfb_pkg::OP_BR_CARRY: m = c;
            lfb_pkg::OP_BR_NO_CARRY: m = ~c;
            lfb_pkg::OP_BR_NEG: m = n;
            lfb_pkg::OP_BR_NOT_NEG: m = ~n;
            lfb_pkg::OP_BR_NO_OVF: m = ~ov;
            default: m = 1'b0;
        endcase
        return m;
    endfunction

    // Word offset doubled and sign extended to the counter width.
    function automatic logic [lfb_pkg::PC_W-1:0] branch_disp(input logic [7:0] n);
        return {{(lfb_pkg::PC_W - 9){n[lfb_pkg::SIGN_BIT]}}, n, 1'b0};
    endfunction

    assign op = op_decode(ir_q);
    assign taken = cond_met(op, i_carry_flag, neg_q, i_overflow_flag);

    lfb_addr_form u_addr_form (
        .i_bank_bit(ir_q[lfb_pkg::BANK_BIT]),
        .i_file_addr(ir_q[7:0]),
        .i_bank_select_pointer(i_bank_select_pointer),
        .i_ext_set_en(i_ext_set_en),
        .i_index_base(i_index_base),
        .o_data_addr(operand_addr)
    );

    // Next-state logic for one instruction cycle split into four phases.
    always_comb
    begin
        phase_d = phase_q;
        ir_d = ir_q;
        pc_d = pc_q;
        wreg_d = wreg_q;
        res_d = res_q;
        neg_d = neg_q;
        zero_d = zero_q;
        flush_d = flush_q;
        addr_d = addr_q;
        rd_d = 1'b0;
        we_d = 1'b0;
        wdata_d = wdata_q;
        unique case (phase_q)
            lfb_pkg::PH_DECODE:
            begin
                // A word fetched behind a taken branch is replaced by a no-op.
                ir_d = flush_q ? lfb_pkg::NOP_WORD : i_instr;
                phase_d = lfb_pkg::PH_READ;
            end
            lfb_pkg::PH_READ:
            begin
                // The operand address and read strobe are registered here and driven in the next phase, which also takes the read data.
                if (op == lfb_pkg::OP_AND_FILE || op == lfb_pkg::OP_BIT_CLR)
                begin
                    addr_d = operand_addr;
                    rd_d = 1'b1;
                end
                phase_d = lfb_pkg::PH_PROCESS;
            end
            lfb_pkg::PH_PROCESS:
            begin
                unique case (op)
                    lfb_pkg::OP_AND_IMM: res_d = wreg_q & ir_q[7:0];
                    lfb_pkg::OP_AND_FILE: res_d = wreg_q & i_mem_rdata;
                    lfb_pkg::OP_BIT_CLR:
                        res_d = i_mem_rdata & ~(8'h01 << ir_q[BITIDX_HI:lfb_pkg::BITIDX_LSB]);
                    default: res_d = res_q;
                endcase
                phase_d = lfb_pkg::PH_WRITE;
            end
            lfb_pkg::PH_WRITE:
            begin
                // The discarded cycle keeps the counter on the branch target.
                if (flush_q)
                begin
                    flush_d = 1'b0;
                end
                else if (taken)
                begin
                    pc_d = pc_q + lfb_pkg::PC_STEP + branch_disp(ir_q[7:0]);
                    flush_d = 1'b1;
                end
                else
                begin
                    pc_d = pc_q + lfb_pkg::PC_STEP;
                end
                // Only the AND operations touch the flags; branches and bit clear leave them.
                if (op == lfb_pkg::OP_AND_IMM || op == lfb_pkg::OP_AND_FILE)
                begin
                    neg_d = res_q[7];
                    zero_d = (res_q == 8'h00);
                end
                if (op == lfb_pkg::OP_AND_IMM ||
                    (op == lfb_pkg::OP_AND_FILE && !ir_q[lfb_pkg::DEST_BIT]))
                begin
                    wreg_d = res_q;
                end
                if (op == lfb_pkg::OP_BIT_CLR ||
                    (op == lfb_pkg::OP_AND_FILE && ir_q[lfb_pkg::DEST_BIT]))
                begin
                    we_d = 1'b1;
                    wdata_d = res_q;
                end
                phase_d = lfb_pkg::PH_DECODE;
            end
            default:
            begin
                phase_d = lfb_pkg::PH_DECODE;
            end
        endcase
    end

    // State registers; every output is one of these flip-flops.
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            phase_q <= lfb_pkg::PH_DECODE;
            ir_q <= lfb_pkg::NOP_WORD;
            pc_q <= lfb_pkg::PC_RESET;
            wreg_q <= lfb_pkg::WREG_RESET;
            res_q <= 8'h00;
            neg_q <= 1'b0;
            zero_q <= 1'b0;
            flush_q <= 1'b0;
            addr_q <= lfb_pkg::DADDR_RESET;
            rd_q <= 1'b0;
            we_q <= 1'b0;
            wdata_q <= 8'h00;
        end
        else
        begin
            phase_q <= phase_d;
            ir_q <= ir_d;
            pc_q <= pc_d;
            wreg_q <= wreg_d;
            res_q <= res_d;
            neg_q <= neg_d;
            zero_q <= zero_d;
            flush_q <= flush_d;
            addr_q <= addr_d;
            rd_q <= rd_d;
            we_q <= we_d;
            wdata_q <= wdata_d;
        end
    end

    assign o_phase = phase_q;
    assign o_pc = pc_q;
    assign o_wreg = wreg_q;
    assign o_neg_flag = neg_q;
    assign o_zero_flag = zero_q;
    assign o_mem_addr = addr_q;
    assign o_mem_rd = rd_q;
    assign o_mem_we = we_q;
    assign o_mem_wdata = wdata_q;
    assign o_discard = flush_q;

endmodule

// ### lfb_exec_asserts.sv
// Checker for phase, strobe, branch and flag timing at the ports of lfb_exec.
`timescale 1ns/1ns
module lfb_exec_chk (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [3:0] o_phase,
    input wire logic [lfb_pkg::PC_W-1:0] o_pc,
    input wire logic [7:0] o_wreg,
    input wire logic o_neg_flag,
    input wire logic o_zero_flag,
    input wire logic o_mem_rd,
    input wire logic o_mem_we,
    input wire logic o_discard
);
    // All checks run on the core clock and pause while reset is held.
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst);
    // Phases and strobes; a slipped strobe would hit the wrong memory slot.
    a_phase_hot: assert property ($onehot(o_phase))
        else $error("phase not one-hot");
    a_phase_order: assert property (
        o_phase == 4'h1 |=> o_phase == 4'h2 ##1 o_phase == 4'h4 ##1 o_phase == 4'h8
        ##1 o_phase == 4'h1)
        else $error("phase order broken");
    a_read_slot: assert property (o_mem_rd |-> o_phase == 4'h4 && $past(o_phase) == 4'h2)
        else $error("read strobe out of slot");
    a_write_slot: assert property (o_mem_we |-> o_phase == 4'h1 && $past(o_mem_rd, 2))
        else $error("write strobe out of slot");
    a_strobe_pulse: assert property (o_mem_rd || o_mem_we |=> !o_mem_rd && !o_mem_we)
        else $error("strobe longer than one clock");
    // Branch timing and the discarded cycle.
    a_pc_hold: assert property (o_phase != 4'h1 |-> $stable(o_pc))
        else $error("pc moved inside an instruction");
    a_discard_len: assert property ($rose(o_discard) |-> o_discard [*4] ##1 !o_discard)
        else $error("discard cycle length wrong");
    a_discard_quiet: assert property (
        o_discard |-> !o_mem_rd && !o_mem_we && $stable(o_wreg))
        else $error("activity during discard cycle");
    // A zero result can never be negative, and flags only move at the write edge.
    a_flags_apart: assert property (
        $changed(o_zero_flag) || $changed(o_neg_flag) |-> o_phase == 4'h1
        && !(o_zero_flag && o_neg_flag))
        else $error("flag update inconsistent");
    c_taken: cover property ($rose(o_discard));
    c_write: cover property (o_mem_we);
    c_zero: cover property ($rose(o_zero_flag));
    c_negative: cover property ($rose(o_neg_flag));
endmodule
bind lfb_exec lfb_exec_chk u_chk (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .o_phase(o_phase), .o_pc(o_pc),
    .o_wreg(o_wreg), .o_neg_flag(o_neg_flag), .o_zero_flag(o_zero_flag),
    .o_mem_rd(o_mem_rd), .o_mem_we(o_mem_we), .o_discard(o_discard)
);

// ### lfb_pkg.sv
// Constants, opcode codes and types shared by the logic and flag branch slice.
// Notes on behaviour
// - AND literal with working register, update N, Z.
// - AND register; destination bit picks W or file.
// - Bank bit clear: access bank; set: bank pointer.
// - Extended set, access, operand up to 5Fh: indexed.
// - Bit clear in one cycle, flags untouched.
// - Taken branch: PC plus two plus twice offset.
// - Taken branch two cycles, second all no-operations.
// - Opcode E2h branches when carry is one.
// - Opcode E3h branches when carry is zero.
// - Opcode E6h branches when negative is one.
// - Opcode E7h branches when negative is zero.
// - Opcode E5h branches when overflow is zero.
package lfb_pkg;

    localparam int INSTR_W = 16;
    localparam int PC_W = 21;
    localparam int DADDR_W = 12;

    // Opcode fields and codes.
    localparam logic [7:0] OPC_AND_IMM = 8'h0B;
    localparam logic [5:0] OPC_AND_FILE = 6'h05;
    localparam logic [3:0] OPC_BIT_CLR = 4'h9;
    localparam logic [7:0] OPC_BR_CARRY = 8'hE2;
    localparam logic [7:0] OPC_BR_NO_CARRY = 8'hE3;
    localparam logic [7:0] OPC_BR_NEG = 8'hE6;
    localparam logic [7:0] OPC_BR_NOT_NEG = 8'hE7;
    localparam logic [7:0] OPC_BR_NO_OVF = 8'hE5;
    localparam logic [INSTR_W-1:0] NOP_WORD = 16'h0000;

    // Field positions inside the instruction word.
    localparam int DEST_BIT = 9;
    localparam int BANK_BIT = 8;
    localparam int BITIDX_LSB = 9;
    localparam int SIGN_BIT = 7;

    // Access bank split and the bank that the upper half maps to.
    localparam logic [7:0] ACCESS_SPLIT = 8'h5F;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;

    // Program counter step per instruction word and reset values.
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    // All ones, so that the first AND passes its operand through; with a zero
    // reset the working register could never leave zero inside this slice.
    localparam logic [7:0] WREG_RESET = 8'hFF;
    localparam logic [DADDR_W-1:0] DADDR_RESET = 12'h000;

    // Quarter phases of one instruction cycle, one-hot.
    typedef enum logic [3:0] {
        PH_DECODE = 4'b0001,
        PH_READ = 4'b0010,
        PH_PROCESS = 4'b0100,
        PH_WRITE = 4'b1000
    } lfb_phase_e;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_AND_IMM,
        OP_AND_FILE,
        OP_BIT_CLR,
        OP_BR_CARRY,
        OP_BR_NO_CARRY,
        OP_BR_NEG,
        OP_BR_NOT_NEG,
        OP_BR_NO_OVF
    } lfb_op_e;

endpackage

// ### tb_lfb_exec.sv
// Self-checking bench for lfb_exec: an instruction table, then reset cases.
`timescale 1ns/1ns
module tb_lfb_exec;
    typedef struct packed {
        logic [15:0] ins;
        logic [7:0] rd;
        logic [3:0] cvet;
        logic [7:0] wd;
        logic [11:0] ad;
    } lfb_row_s;
    logic i_sys_clk, i_nrst, i_ext_set_en, i_carry_flag, i_overflow_flag;
    logic [15:0] i_instr;
    logic [7:0] i_mem_rdata, o_wreg, o_mem_wdata, exp_w, res;
    logic [3:0] i_bank_select_pointer, o_phase;
    logic [11:0] i_index_base, o_mem_addr;
    logic [20:0] o_pc, exp_pc;
    logic o_neg_flag, o_zero_flag, o_mem_rd, o_mem_we, o_discard;
    logic exp_n, exp_z, andi, andf, wr;
    lfb_row_s r;
    int fails, checks_done, cycles;
    // Row: word, read data, {carry, overflow, ext set, taken}, write data, address.
    // Bit clears come first so that flags are seen to stay at their reset value.
    // The AND rows set the negative flag first and the zero flag later, so that
    // both outcomes of both negative branches are seen.
    lfb_row_s rows [19] = '{
        48'h9E80_C7_0_47_F80, 48'h9112_FF_0_FE_312, 48'h9A5F_FF_2_DF_15F,
        48'h9C60_FF_2_BF_F60, 48'h0BC3_00_0_00_000, 48'h1620_C2_0_C2_020,
        48'h1580_C2_0_00_380, 48'hE67F_00_1_00_000, 48'hE77F_00_0_00_000,
        48'h0B00_00_0_00_000, 48'hE77F_00_1_00_000, 48'hE67F_00_0_00_000,
        48'hE205_00_9_00_000, 48'hE205_00_0_00_000, 48'hE3F0_00_1_00_000,
        48'hE3F0_00_8_00_000, 48'hE580_00_1_00_000, 48'hE580_00_4_00_000,
        48'hFFFF_00_0_00_000
    };

    lfb_exec uut (
        .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_instr(i_instr),
        .i_mem_rdata(i_mem_rdata), .i_bank_select_pointer(i_bank_select_pointer),
        .i_ext_set_en(i_ext_set_en), .i_index_base(i_index_base),
        .i_carry_flag(i_carry_flag), .i_overflow_flag(i_overflow_flag),
        .o_phase(o_phase), .o_pc(o_pc), .o_wreg(o_wreg), .o_neg_flag(o_neg_flag),
        .o_zero_flag(o_zero_flag), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd),
        .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata), .o_discard(o_discard)
    );

    // The clock runs at 100 MHz.
    initial
    begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    // A hang is cut short well beyond the 123 cycles the run needs.
    always @(posedge i_sys_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fails++;
            stop_test();
        end
    end

    task automatic chk(input string n, input logic [20:0] e, input logic [20:0] g);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("[FAIL] %s expected %h got %h", n, e, g);
        end
    endtask

    // Presents one word at decode and returns at the next decode phase.
    task automatic exec(input logic [15:0] ins, input logic [7:0] rd, input logic [3:0] f);
        i_instr = ins;
        i_mem_rdata = rd;
        i_carry_flag = f[3];
        i_overflow_flag = f[2];
        i_ext_set_en = f[1];
        repeat (4) @(negedge i_sys_clk);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Main sequence: reset, the table, then a reset in mid-instruction.
    initial
    begin
        {i_nrst, i_ext_set_en, i_carry_flag, i_overflow_flag} = 4'h0;
        {i_instr, i_mem_rdata} = 24'h000000;
        i_bank_select_pointer = 4'h3;
        i_index_base = 12'h100;
        {exp_pc, exp_w, exp_n, exp_z} = 31'h0;
        exp_w = lfb_pkg::WREG_RESET;
        repeat (20) @(negedge i_sys_clk);
        chk("reset phase", 21'h1, 21'(o_phase));
        chk("reset zero", 21'h0, 21'(o_zero_flag));
        chk("reset wreg", 21'(lfb_pkg::WREG_RESET), 21'(o_wreg));
        chk("reset pc", 21'(lfb_pkg::PC_RESET), o_pc);
        i_nrst = 1'b1;
        for (int k = 0; k < 19; k++)
        begin
            r = rows[k];
            andi = (r.ins[15:8] == 8'h0B);
            andf = (r.ins[15:10] == 6'h05);
            wr = (r.ins[15:12] == 4'h9) || (andf && r.ins[9]);
            exec(r.ins, r.rd, r.cvet);
            if (andi || andf)
            begin
                res = exp_w & (andi ? r.ins[7:0] : r.rd);
                exp_z = (res == 8'h00);
                exp_n = res[7];
                if (!wr)
                    exp_w = res;
            end
            exp_pc = exp_pc + 21'h2 + (r.cvet[0] ? {{12{r.ins[7]}}, r.ins[7:0], 1'b0} : 21'h0);
            chk("pc", exp_pc, o_pc);
            chk("wreg", 21'(exp_w), 21'(o_wreg));
            chk("zero", 21'(exp_z), 21'(o_zero_flag));
            chk("neg", 21'(exp_n), 21'(o_neg_flag));
            chk("write", 21'(wr), 21'(o_mem_we));
            if (wr)
                chk("wdata", 21'(r.wd), 21'(o_mem_wdata));
            if (wr || andf)
                chk("addr", 21'(r.ad), 21'(o_mem_addr));
            chk("taken", 21'(r.cvet[0]), 21'(o_discard));
            if (r.cvet[0])
            begin
                exec(16'h9E80, 8'hFF, 4'h0);
                chk("skip pc", exp_pc, o_pc);
                chk("skip write", 21'h0, 21'(o_mem_we));
                chk("skip end", 21'h0, 21'(o_discard));
            end
        end
        // Reset in the process phase must drop the read strobe and all state.
        i_instr = 16'h9E80;
        repeat (2) @(negedge i_sys_clk);
        i_nrst = 1'b0;
        @(negedge i_sys_clk);
        chk("mid phase", 21'h1, 21'(o_phase));
        chk("mid pc", 21'h0, o_pc);
        chk("mid read", 21'h0, 21'(o_mem_rd));
        i_nrst = 1'b1;
        exec(16'hE205, 8'h00, 4'h8);
        chk("pc after", 21'hC, o_pc);
        chk("discard after", 21'h1, 21'(o_discard));
        stop_test();
    end
endmodule
